// ---- verilog/gsp_defines.svh ----
// constants of the rate sensor serial register port
`ifndef GSP_DEFINES_SVH
`define GSP_DEFINES_SVH

`define GSP_MCLK_HZ          100000000
`define GSP_MCLK_PERIOD_NS   10
`define GSP_FRAME_BITS       16
`define GSP_WORDS            64
`define GSP_ADDR_W           7
`define GSP_ADDR_RATE        7'h04
`define GSP_ADDR_EXT         7'h06
`define GSP_ADDR_OFFSET      7'h14
`define GSP_ADDR_SCALE       7'h16
`define GSP_ADDR_ALM_MAG     7'h20
`define GSP_ADDR_ID          7'h56
`define GSP_WR_LOW           7'h14
`define GSP_WR_HIGH          7'h51
`define GSP_SCALE_RESET      16'h0800
`define GSP_SCALE_SHIFT      11
`define GSP_NEW_BIT          15
`define GSP_ALARM_BIT        14
`define GSP_SAMPLE_RATE_SPS  2429
`define GSP_SAMPLE_CYCLES    (`GSP_MCLK_HZ / `GSP_SAMPLE_RATE_SPS)
`define GSP_DRDY_NS          40
`define GSP_DRDY_CYCLES      ((`GSP_DRDY_NS + `GSP_MCLK_PERIOD_NS - 1) / `GSP_MCLK_PERIOD_NS)
`define GSP_STALL_US         9
`define GSP_DATARATE_US      32

`endif

// ---- verilog/gsp_pkg.sv ----
// types of the rate sensor serial register port
package gsp_pkg;

    // one request frame as it arrives on the data input
    typedef struct packed {
        logic       rd_n;
        logic [6:0] addr;
        logic [7:0] data;
    } gsp_req_t;

    // steps of one internal sample cycle
    typedef enum logic [2:0] {
        GSP_WAIT,
        GSP_CORRECT,
        GSP_FILTER,
        GSP_ALARM,
        GSP_LOAD
    } gsp_smp_state_t;

endpackage

// ---- verilog/gsp_spi_port.sv ----
// serial register port and sample engine of the rate sensor
`timescale 1ns/1ps
`default_nettype none
`include "gsp_defines.svh"

module gsp_spi_port
    import gsp_pkg::*;
#(
    parameter int unsigned SAMPLE_CYCLES = `GSP_SAMPLE_CYCLES,
    parameter logic [15:0] ID_CODE       = 16'h5A5A  // arbitrary value
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        din,
    output logic             dout,
    output logic             dout_oe,
    input  wire logic [13:0] sense_raw,
    output logic             data_ready_line,
    output logic             data_ready_line_oe
);

    function automatic logic [5:0] gsp_word(input logic [6:0] a);
        return a[6:1];
    endfunction

    // ---------------- link side, on the master's serial clock ----------------
    logic [3:0]  rcnt_reg;
    logic [14:0] rsh_reg;
    gsp_req_t    rx_hold_reg;
    logic        req_tgl_reg;
    logic [3:0]  fcnt_reg;
    logic [15:0] tsh_reg;
    logic [15:0] rd_data_reg;
    logic        prev_read_reg;

    // input shift; chip select high clears the frame, so no clock edge is needed to end it
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            rcnt_reg <= 4'h0;
            rsh_reg  <= 15'h0000;
        end else begin
            rcnt_reg <= rcnt_reg + 4'h1;
            rsh_reg  <= {rsh_reg[13:0], din};
        end
    end

    // completed request and its event toggle survive the frame end; the synchronised
    // reset copy is used so the whole block leaves reset together
    always_ff @(posedge sclk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            rx_hold_reg <= '0;
            req_tgl_reg <= 1'b0;
        end else if (rcnt_reg == 4'hF) begin
            rx_hold_reg <= {rsh_reg, din};
            req_tgl_reg <= ~req_tgl_reg;
        end
    end

    // output shift on falling edges; answer word is stable for the whole frame because
    // the master's stall gap leaves the system side ample time to prepare it
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            fcnt_reg <= 4'h0;
            tsh_reg  <= 16'h0000;
        end else begin
            fcnt_reg <= fcnt_reg + 4'h1;
            if (fcnt_reg == 4'h0) begin
                // first falling edge keeps the msb up so the first rising edge takes it
                tsh_reg <= rd_data_reg;
            end else begin
                tsh_reg <= {tsh_reg[14:0], 1'b0};
            end
        end
    end

    // msb shows as soon as chip select falls, before any clock edge
    assign dout    = (fcnt_reg == 4'h0) ? rd_data_reg[15] : tsh_reg[15];
    assign dout_oe = ~cs_n & prev_read_reg;

    // ---------------- system side ----------------
    logic rst_meta_reg;
    logic rst_sys_n;
    logic tgl_meta_reg;
    logic tgl_sync_reg;
    logic tgl_seen_reg;
    logic req_evt;
    gsp_req_t req;

    // reset release through two flops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sys_n    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sys_n    <= rst_meta_reg;
        end
    end

    // request toggle crossing; the edge detect compares the second flop with the third, never the first
    always_ff @(posedge mclk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            tgl_meta_reg <= 1'b0;
            tgl_sync_reg <= 1'b0;
            tgl_seen_reg <= 1'b0;
        end else begin
            tgl_meta_reg <= req_tgl_reg;
            tgl_sync_reg <= tgl_meta_reg;
            tgl_seen_reg <= tgl_sync_reg;
        end
    end

    assign req_evt = tgl_sync_reg ^ tgl_seen_reg;
    assign req     = rx_hold_reg;   // held since the toggle, so safe to read here

    // sample engine state
    gsp_smp_state_t      st_reg;
    logic [31:0]         tmr_reg;
    logic signed [31:0]  prod_reg;
    logic signed [15:0]  corr_reg;
    logic signed [15:0]  filt_reg;
    logic                alarm_reg;
    logic [3:0]          drdy_cnt_reg;
    logic [15:0]         regs [0:`GSP_WORDS-1];
    logic signed [16:0]  filt_sum;
    logic [15:0]         filt_abs;

    assign filt_sum = 17'(filt_reg) + 17'(corr_reg);
    assign filt_abs = filt_reg[15] ? 16'(-filt_reg) : filt_reg;

    // sample timer starts counting straight out of reset
    always_ff @(posedge mclk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            tmr_reg <= 32'h00000000;
        end else if (tmr_reg >= SAMPLE_CYCLES - 1) begin
            tmr_reg <= 32'h00000000;
        end else begin
            tmr_reg <= tmr_reg + 32'h00000001;
        end
    end

    // correction, filter and alarm steps of each sample
    always_ff @(posedge mclk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            st_reg    <= GSP_WAIT;
            prod_reg  <= 32'sh00000000;
            corr_reg  <= 16'sh0000;
            filt_reg  <= 16'sh0000;
            alarm_reg <= 1'b0;
        end else begin
            case (st_reg)
                GSP_WAIT: begin
                    if (tmr_reg >= SAMPLE_CYCLES - 1) begin
                        st_reg   <= GSP_CORRECT;
                        prod_reg <= 32'($signed(sense_raw))
                                  * 32'($signed({1'b0, regs[gsp_word(`GSP_ADDR_SCALE)]}));
                    end
                end
                GSP_CORRECT: begin
                    corr_reg <= 16'(prod_reg >>> `GSP_SCALE_SHIFT)
                              + $signed(regs[gsp_word(`GSP_ADDR_OFFSET)]);
                    st_reg   <= GSP_FILTER;
                end
                GSP_FILTER: begin
                    filt_reg <= 16'(filt_sum >>> 1);
                    st_reg   <= GSP_ALARM;
                end
                GSP_ALARM: begin
                    // zero magnitude leaves the alarm disabled
                    alarm_reg <= (regs[gsp_word(`GSP_ADDR_ALM_MAG)] != 16'h0000)
                              && (filt_abs > regs[gsp_word(`GSP_ADDR_ALM_MAG)]);
                    st_reg    <= GSP_LOAD;
                end
                GSP_LOAD: begin
                    st_reg <= GSP_WAIT;
                end
                default: begin
                    st_reg <= GSP_WAIT;
                end
            endcase
        end
    end

    // data ready pulse after each load
    always_ff @(posedge mclk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            drdy_cnt_reg <= 4'h0;
        end else if (st_reg == GSP_LOAD) begin
            drdy_cnt_reg <= 4'(`GSP_DRDY_CYCLES);
        end else if (drdy_cnt_reg != 4'h0) begin
            drdy_cnt_reg <= drdy_cnt_reg - 4'h1;
        end
    end

    assign data_ready_line    = (drdy_cnt_reg != 4'h0);
    assign data_ready_line_oe = rst_sys_n;

    // user register words; output words are loaded by the engine only
    always_ff @(posedge mclk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            for (int i = 0; i < `GSP_WORDS; i++) begin
                regs[i] <= 16'h0000;
            end
            regs[gsp_word(`GSP_ADDR_SCALE)] <= `GSP_SCALE_RESET;
            regs[gsp_word(`GSP_ADDR_ID)]    <= ID_CODE;
        end else begin
            // a read of the rate word clears its new-data flag; a same-cycle load wins
            if (req_evt && !req.rd_n && gsp_word(req.addr) == gsp_word(`GSP_ADDR_RATE)) begin
                regs[gsp_word(`GSP_ADDR_RATE)][`GSP_NEW_BIT] <= 1'b0;
            end
            if (req_evt && req.rd_n
                && req.addr >= `GSP_WR_LOW && req.addr <= `GSP_WR_HIGH) begin
                if (req.addr[0]) begin
                    regs[gsp_word(req.addr)][15:8] <= req.data;
                end else begin
                    regs[gsp_word(req.addr)][7:0]  <= req.data;
                end
            end
            if (st_reg == GSP_LOAD) begin
                regs[gsp_word(`GSP_ADDR_RATE)] <= {1'b1, alarm_reg, filt_reg[13:0]};
                regs[gsp_word(`GSP_ADDR_EXT)]  <= {prod_reg[10:0], 5'h00};
            end
        end
    end

    // answer word for the next frame; a write leaves the line released next frame
    always_ff @(posedge mclk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            rd_data_reg   <= 16'h0000;
            prev_read_reg <= 1'b0;
        end else if (req_evt) begin
            prev_read_reg <= ~req.rd_n;
            if (!req.rd_n) begin
                rd_data_reg <= regs[gsp_word(req.addr)];
            end
        end
    end

    // ---------------- checks ----------------
    AST_DRDY_WIDTH: assert property (@(posedge mclk) disable iff (!rst_sys_n)
        $rose(data_ready_line) |-> data_ready_line [*4] ##1 !data_ready_line)
        else $error("data ready pulse width wrong");

    AST_LOAD_PULSE: assert property (@(posedge mclk) disable iff (!rst_sys_n)
        st_reg == GSP_LOAD |=> $rose(data_ready_line))
        else $error("no data ready pulse after load");

    AST_SAMPLE_SEQ: assert property (@(posedge mclk) disable iff (!rst_sys_n)
        st_reg == GSP_CORRECT |=> st_reg == GSP_FILTER ##1 st_reg == GSP_ALARM
                                  ##1 st_reg == GSP_LOAD ##1 st_reg == GSP_WAIT)
        else $error("sample steps out of order");

    AST_AUTOSTART: assert property (@(posedge mclk) disable iff (!rst_sys_n)
        (st_reg == GSP_WAIT && tmr_reg == SAMPLE_CYCLES - 1) |=> st_reg == GSP_CORRECT)
        else $error("sample cycle did not start");

    AST_READ_WORD: assert property (@(posedge mclk) disable iff (!rst_sys_n)
        (req_evt && !req.rd_n && st_reg != GSP_LOAD)
        |=> rd_data_reg == $past(regs[gsp_word(req.addr)]) && prev_read_reg)
        else $error("read answer not loaded");

    AST_WRITE_BYTE: assert property (@(posedge mclk) disable iff (!rst_sys_n)
        (req_evt && req.rd_n && req.addr == `GSP_ADDR_OFFSET + 7'h01)
        |=> regs[gsp_word(`GSP_ADDR_OFFSET)][15:8] == $past(req.data) && !prev_read_reg)
        else $error("upper byte write lost");

    AST_HIZ: assert property (@(posedge mclk) disable iff (!rst_sys_n)
        cs_n |-> !dout_oe)
        else $error("output driven while deselected");

    AST_MSB_FIRST: assert property (@(posedge sclk) disable iff (cs_n)
        fcnt_reg == 4'h1 |-> dout == rd_data_reg[15])
        else $error("msb not presented first");

    AST_SHIFT: assert property (@(negedge sclk) disable iff (cs_n)
        fcnt_reg == 4'h1 |=> dout == $past(tsh_reg[14]))
        else $error("output did not shift on falling edge");

endmodule
`default_nettype wire

// ---- sim/gsp_spi_master_model.sv ----
// spi master model that drives the sensor port in mode 3
`timescale 1ns/1ps
`default_nettype none
module gsp_spi_master_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic miso,
    input  wire logic miso_oe
);
    // idle: clock high and still, port deselected
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din  = 1'b0;
    end

    // one frame, msb first; data moves after falling edges, is taken on rising ones
    task automatic xfer(input logic [15:0] tx, input int nbits,
                        output logic [15:0] rx, output logic oe_seen);
        rx      = 16'h0000;
        oe_seen = 1'b0;
        cs_n    = 1'b0;
        // bench runs the link far above the rated clock to keep the run short
        #3;
        for (int i = 0; i < nbits; i++) begin
            sclk = 1'b0;
            din  = tx[15 - i];
            #3;
            sclk    = 1'b1;
            rx      = {rx[14:0], miso};
            oe_seen = oe_seen | miso_oe;
            #3;
        end
        cs_n = 1'b1;
        din  = ~din; // released line must not keep a stale level
        // long gap covers both the stall time and the data period
        #32000;
    endtask
endmodule
`default_nettype wire

// ---- sim/gsp_spi_port_tb.sv ----
// self-checking bench of the sensor serial register port
`timescale 1ns/1ps
`default_nettype none
module gsp_spi_port_tb;
    typedef struct packed {
        logic [16:0] val;
        logic [16:0] msk;
    } gsp_exp_t;
    localparam logic [15:0] ID_VAL = 16'hC3A5; // arbitrary value
    logic        mclk;
    logic        rst_n;
    logic [13:0] sense_raw;
    logic        dout;
    logic        dout_oe;
    logic        data_ready_line;
    logic        data_ready_line_oe;
    wire logic   sclk;
    wire logic   cs_n;
    wire logic   din;
    // an undriven data out line toggles so stale bits cannot pass
    wire logic   miso = dout_oe ? dout : ~dout;
    gsp_exp_t    exq[$];
    gsp_exp_t    cur_exp;
    event        got;
    logic [16:0] seen;
    logic [15:0] rx_dump;
    logic        oe_dump;
    int          bad_count;
    int          compares;
    int          cyc;
    int          run;
    int          pulses;

    gsp_spi_port #(.SAMPLE_CYCLES(50), .ID_CODE(ID_VAL)) u_gsp_spi_port (
        .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout), .dout_oe(dout_oe), .sense_raw(sense_raw),
        .data_ready_line(data_ready_line), .data_ready_line_oe(data_ready_line_oe)
    );
    gsp_spi_master_model u_gsp_spi_master_model (
        .sclk(sclk), .cs_n(cs_n), .din(din), .miso(miso), .miso_oe(dout_oe)
    );

    initial mclk = 1'b0;
    always #5 mclk = ~mclk;

    task automatic check(input logic [16:0] s, input logic [16:0] e, input string msg);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, s, e);
        end
    endtask

    task automatic summarize();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // note the answer this frame should carry, then run it
    task automatic frame(input logic [15:0] tx, input logic [16:0] ev, input logic [16:0] em);
        logic [15:0] rx;
        logic        oe;
        exq.push_back('{val: ev, msk: em});
        u_gsp_spi_master_model.xfer(tx, 16, rx, oe);
        seen = {oe, rx};
        ->got;
        check({16'h0000, dout_oe}, 17'h00000, "driven while deselected");
        $display("frame %h done", tx);
    endtask

    // monitor: each finished frame is matched with the oldest note
    initial forever begin
        @(got);
        cur_exp = exq.pop_front();
        check(seen & cur_exp.msk, cur_exp.val & cur_exp.msk, "frame answer");
    end

    // new raw samples every cycle, off the sampling edge
    always @(negedge mclk)
        sense_raw <= 14'($urandom);

    // ready pulse width and count, plus the hang limit; looked at off the launching edge
    always @(negedge mclk) begin
        if (data_ready_line)
            run++;
        else if (run != 0) begin
            check(run[16:0], 17'h00004, "ready pulse width");
            pulses++;
            run = 0;
        end
        cyc++;
        if (cyc == 80000) begin
            bad_count++;
            summarize();
        end
    end

    initial begin
        rst_n     = 1'b0;
        void'($urandom(32'hB50D9DF6));
        repeat (20) @(posedge mclk);
        @(negedge mclk) rst_n = 1'b1;
        repeat (10) @(negedge mclk);
        check({16'h0000, data_ready_line_oe}, 17'h00001, "ready line idle");
        frame(16'h5600, 17'h00000, 17'h10000);
        frame(16'h1600, {1'b1, ID_VAL}, 17'h1FFFF);
        frame(16'h1700, 17'h10800, 17'h1FFFF);
        frame(16'h2000, 17'h10800, 17'h1FFFF);
        frame(16'h9434, 17'h10000, 17'h1FFFF);
        frame(16'h9512, 17'h00000, 17'h10000);
        frame(16'hD6FF, 17'h00000, 17'h10000);
        // cut frame must be dropped whole
        u_gsp_spi_master_model.xfer(16'h9400, 8, rx_dump, oe_dump);
        frame(16'h1400, 17'h00000, 17'h10000);
        frame(16'h5600, 17'h11234, 17'h1FFFF);
        frame(16'h0400, {1'b1, ID_VAL}, 17'h1FFFF);
        frame(16'h0600, 17'h18000, 17'h1C000);
        frame(16'h0C00, 17'h10000, 17'h1001F);
        frame(16'h0400, 17'h10000, 17'h1FFFF);
        frame(16'h0000, 17'h18000, 17'h1C000);
        // second reset in mid-run must clear the answer state and the written word
        @(negedge mclk) rst_n = 1'b0;
        repeat (20) @(negedge mclk);
        rst_n = 1'b1;
        repeat (10) @(negedge mclk);
        frame(16'h1400, 17'h00000, 17'h10000);
        frame(16'h0000, 17'h10000, 17'h1FFFF);
        check({16'h0000, pulses != 0}, 17'h00001, "no ready pulses");
        summarize();
    end
endmodule
`default_nettype wire
